// file: sense_pkg.sv
package sense_pkg;
  localparam int ADR_W = 4;
  localparam int DAT_W = 32;
  // Register byte addresses
  localparam logic [ADR_W-1:0] ADDR_SELECT = 4'h0;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] ADDR_IRQ_EN = 4'h8;
  localparam logic [ADR_W-1:0] ADDR_FLAGS = 4'hC;
  // Field positions in the select register
  localparam int BIT_HIGH_SEL = 6;
  localparam int BIT_LOW_SEL_HI = 5;
  localparam int BIT_LOW_SEL_LO = 4;
  localparam int BIT_SUP_ADC = 3;
  localparam int BIT_SUP_SENSE = 2;
  localparam int BIT_SEN_ADC = 1;
  localparam int BIT_SEN_SENSE = 0;
  // Field positions shared by status, enable and flag registers
  localparam int BIT_HIGH = 1;
  localparam int BIT_LOW = 0;
  // Implemented bit masks, all other bits read zero
  localparam logic [7:0] MASK_SELECT = 8'h7F;
  localparam logic [7:0] MASK_PAIR = 8'h03;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Cycles that change detection stays paused after stop ends (synchroniser depth)
  localparam logic [1:0] WAKE_HOLD = 2'h2;
endpackage

// file: cond_if.sv
// Synchronised comparator conditions handed to the register block
interface cond_if;
  logic high_condition;
  logic low_condition;
  modport src (output high_condition, output low_condition);
  modport dst (input high_condition, input low_condition);
endinterface

// file: cond_sync.sv
module cond_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmp_high,
  input wire logic cmp_low,
  input wire logic sense_on,
  cond_if.src cond
);
  import sense_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // Two-stage capture; only the second stage is looked at
  always_comb begin
    st_next = st_reg;
    st_next.meta = {cmp_high, cmp_low};
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cond.high_condition = sense_on & st_reg.stable[BIT_HIGH];
  assign cond.low_condition = sense_on & st_reg.stable[BIT_LOW];
endmodule

// file: supply_voltage_sense_ctrl.sv
// Overview of operation
// - Bit 6 picks high threshold, 0 first level, 1 second level.
// - Bits 5:4 pick one of four low thresholds.
// - Supply ADC connect sets only while sense ADC connect is clear.
// - Supply level sense sets only while sense level sense is clear.
// - Setting sense ADC connect clears supply ADC connect.
// - Setting sense level sense clears supply level sense.
// - Select and interrupt enable registers are freely readable and writable.
// - Status register is read-only; writes ignored.
// - Status bit 1 follows comparator high condition.
// - Status bit 0 follows comparator low condition.
// - High flag sets on any change of high condition.
// - Low flag sets on any change of low condition.
// - Writing 1 clears a flag, 0 leaves it.
// - High enable gates high flag to an interrupt request.
// - Low enable gates low flag to an interrupt request.
// - Both requests merge into one interrupt output.
// - With both level senses off, conditions read zero.
// - Stop mode leaves flags and configuration untouched.
// - Unimplemented bits read zero.
//
// Chosen here: the Wishbone register port and the register addresses.
module supply_voltage_sense_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sense_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [sense_pkg::DAT_W-1:0] wb_dat_i,
  output logic [sense_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmp_high,
  input wire logic cmp_low,
  input wire logic stop_mode,
  output logic high_level_select,
  output logic [1:0] low_level_select,
  output logic battery_sense_pin_adc_path,
  output logic chip_supply_pin_adc_path,
  output logic battery_sense_pin_cmp_path,
  output logic chip_supply_pin_cmp_path,
  output logic module_irq
);
  import sense_pkg::*;

  typedef struct packed {
    logic [7:0] select;
    logic [1:0] irq_en;
    logic [1:0] flags;
    logic [1:0] cond_prev;
    logic [1:0] wake_cnt;
    logic ack;
    logic [DAT_W-1:0] rdata;
  } ctrl_s;

  ctrl_s st_reg;
  ctrl_s st_next;
  logic sense_on;
  logic req;
  logic wr_byte;
  logic [7:0] wbyte;
  logic [1:0] cond_now;
  logic [1:0] changed;
  logic frozen;
  cond_if cond ();

  // Pack the registered conditions into one status field
  function automatic logic [7:0] pair_byte(input logic [1:0] v);
    pair_byte = {6'h00, v} & MASK_PAIR;
  endfunction

  // Level sense is on when either pin feeds the comparator
  assign sense_on = st_reg.select[BIT_SEN_SENSE] | st_reg.select[BIT_SUP_SENSE];

  cond_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cmp_high(cmp_high),
    .cmp_low(cmp_low),
    .sense_on(sense_on),
    .cond(cond)
  );

  assign cond_now = {cond.high_condition, cond.low_condition};
  // detection paused in stop and while the synchroniser refills after it
  assign frozen = stop_mode | (st_reg.wake_cnt != 2'h0);
  // edge seen in either direction; a paused cycle never counts as a change
  assign changed = frozen ? 2'h0 : (cond_now ^ st_reg.cond_prev);

  // Request is new when ack is not already up, giving one registered ack per access
  assign req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  // Only byte lane 0 holds register data
  assign wr_byte = req & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // Next state of registers, flags and bus answer
  always_comb begin
    logic [7:0] sel;
    sel = st_reg.select;
    st_next = st_reg;
    st_next.ack = req;
    // last condition kept while paused, so waking finds no false change
    if (!frozen) begin
      st_next.cond_prev = cond_now;
    end
    // Counter held at WAKE_HOLD in stop, drained once stop ends
    if (stop_mode) begin
      st_next.wake_cnt = WAKE_HOLD;
    end else if (st_reg.wake_cnt != 2'h0) begin
      st_next.wake_cnt = st_reg.wake_cnt - 2'h1;
    end

    if (wr_byte && wb_adr_i == ADDR_SELECT) begin
      sel[BIT_HIGH_SEL] = wbyte[BIT_HIGH_SEL];
      sel[BIT_LOW_SEL_HI:BIT_LOW_SEL_LO] = wbyte[BIT_LOW_SEL_HI:BIT_LOW_SEL_LO];
      sel[BIT_SEN_ADC] = wbyte[BIT_SEN_ADC];
      sel[BIT_SEN_SENSE] = wbyte[BIT_SEN_SENSE];
      // supply ADC blocked by sense ADC
      sel[BIT_SUP_ADC] = wbyte[BIT_SUP_ADC] & ~st_reg.select[BIT_SEN_ADC];
      // supply sense blocked by sense sense
      sel[BIT_SUP_SENSE] = wbyte[BIT_SUP_SENSE] & ~st_reg.select[BIT_SEN_SENSE];
      if (wbyte[BIT_SEN_ADC]) begin
        sel[BIT_SUP_ADC] = 1'b0;
      end
      if (wbyte[BIT_SEN_SENSE]) begin
        sel[BIT_SUP_SENSE] = 1'b0;
      end
      st_next.select = sel & MASK_SELECT;
    end

    if (wr_byte && wb_adr_i == ADDR_IRQ_EN) begin
      st_next.irq_en = wbyte[1:0];
    end

    if (wr_byte && wb_adr_i == ADDR_FLAGS) begin
      st_next.flags = st_reg.flags & ~wbyte[1:0];
    end
    st_next.flags = st_next.flags | changed;

    // status not written; unused bits zero
    if (req) begin
      case (wb_adr_i)
        ADDR_SELECT: st_next.rdata = {24'h000000, st_reg.select & MASK_SELECT};
        ADDR_STATUS: st_next.rdata = {24'h000000, pair_byte(cond_now)};
        ADDR_IRQ_EN: st_next.rdata = {24'h000000, pair_byte(st_reg.irq_en)};
        ADDR_FLAGS: st_next.rdata = {24'h000000, pair_byte(st_reg.flags)};
        default: st_next.rdata = '0;
      endcase
    end
  end

  // stop mode has no reset effect on state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Analog path controls; paths open in stop mode but configuration is kept
  assign high_level_select = st_reg.select[BIT_HIGH_SEL];
  assign low_level_select = st_reg.select[BIT_LOW_SEL_HI:BIT_LOW_SEL_LO];
  assign battery_sense_pin_adc_path = st_reg.select[BIT_SEN_ADC] & ~stop_mode;
  assign chip_supply_pin_adc_path = st_reg.select[BIT_SUP_ADC] & ~stop_mode;
  assign battery_sense_pin_cmp_path = st_reg.select[BIT_SEN_SENSE] & ~stop_mode;
  assign chip_supply_pin_cmp_path = st_reg.select[BIT_SUP_SENSE] & ~stop_mode;

  assign module_irq = |(st_reg.flags & st_reg.irq_en);

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;

  property p_flag_on_change;
    @(posedge clk_sys) disable iff (sys_rst)
      changed[BIT_HIGH] |=> st_reg.flags[BIT_HIGH];
  endproperty
  a_flag_on_change: assert property (p_flag_on_change) else $error("high flag missed");

  property p_low_flag;
    @(posedge clk_sys) disable iff (sys_rst)
      changed[BIT_LOW] |=> st_reg.flags[BIT_LOW];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag missed");

  property p_flag_sticky;
    @(posedge clk_sys) disable iff (sys_rst)
      st_reg.flags[BIT_LOW] && !(wr_byte && wb_adr_i == ADDR_FLAGS) |=> st_reg.flags[BIT_LOW];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_irq;
    @(posedge clk_sys) disable iff (sys_rst)
      module_irq == ((st_reg.flags[BIT_HIGH] && st_reg.irq_en[BIT_HIGH])
                     || (st_reg.flags[BIT_LOW] && st_reg.irq_en[BIT_LOW]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_exclusive_adc;
    @(posedge clk_sys) disable iff (sys_rst)
      !(st_reg.select[BIT_SEN_ADC] && st_reg.select[BIT_SUP_ADC]);
  endproperty
  a_exclusive_adc: assert property (p_exclusive_adc) else $error("both adc");

  property p_exclusive_sense;
    @(posedge clk_sys) disable iff (sys_rst)
      !(st_reg.select[BIT_SEN_SENSE] && st_reg.select[BIT_SUP_SENSE]);
  endproperty
  a_exclusive_sense: assert property (p_exclusive_sense) else $error("both sense");

  property p_cond_off;
    @(posedge clk_sys) disable iff (sys_rst)
      !sense_on |-> cond_now == 2'h0;
  endproperty
  a_cond_off: assert property (p_cond_off) else $error("cond not forced");

  property p_top_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_reg.select & ~MASK_SELECT) == 8'h00;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("bit 7 set");

  property p_sync_delay;
    @(posedge clk_sys) disable iff (sys_rst)
      sense_on && $stable(sense_on) && cmp_high ##1 cmp_high && sense_on |=>
        !sense_on || cond.high_condition;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync latency");

  property p_ack_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

  property p_high_sel;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_SELECT |=> high_level_select == $past(wbyte[BIT_HIGH_SEL]);
  endproperty
  a_high_sel: assert property (p_high_sel) else $error("high select not stored");

  property p_low_sel;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_SELECT |=>
        low_level_select == $past(wbyte[BIT_LOW_SEL_HI:BIT_LOW_SEL_LO]);
  endproperty
  a_low_sel: assert property (p_low_sel) else $error("low select not stored");

  property p_sup_adc_block;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_SELECT && st_reg.select[BIT_SEN_ADC] |=>
        !st_reg.select[BIT_SUP_ADC];
  endproperty
  a_sup_adc_block: assert property (p_sup_adc_block) else $error("supply adc set");

  property p_sup_sense_block;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_SELECT && st_reg.select[BIT_SEN_SENSE] |=>
        !st_reg.select[BIT_SUP_SENSE];
  endproperty
  a_sup_sense_block: assert property (p_sup_sense_block) else $error("supply sense set");

  property p_sen_adc_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_SELECT && wbyte[BIT_SEN_ADC] |=>
        st_reg.select[BIT_SEN_ADC] && !st_reg.select[BIT_SUP_ADC];
  endproperty
  a_sen_adc_clear: assert property (p_sen_adc_clear) else $error("adc not moved");

  property p_sen_sense_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_SELECT && wbyte[BIT_SEN_SENSE] |=>
        st_reg.select[BIT_SEN_SENSE] && !st_reg.select[BIT_SUP_SENSE];
  endproperty
  a_sen_sense_clear: assert property (p_sen_sense_clear) else $error("sense not moved");

  property p_irq_en_store;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_IRQ_EN |=> st_reg.irq_en == $past(wbyte[BIT_HIGH:BIT_LOW]);
  endproperty
  a_irq_en_store: assert property (p_irq_en_store) else $error("enable not stored");

  property p_status_high;
    @(posedge clk_sys) disable iff (sys_rst)
      req && wb_adr_i == ADDR_STATUS |=> wb_dat_o[BIT_HIGH] == $past(cond.high_condition);
  endproperty
  a_status_high: assert property (p_status_high) else $error("high status wrong");

  property p_status_low;
    @(posedge clk_sys) disable iff (sys_rst)
      req && wb_adr_i == ADDR_STATUS |=> wb_dat_o[BIT_LOW] == $past(cond.low_condition);
  endproperty
  a_status_low: assert property (p_status_low) else $error("low status wrong");

  property p_flag_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
      !st_reg.flags[BIT_HIGH] && !changed[BIT_HIGH] |=> !st_reg.flags[BIT_HIGH];
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("high flag without change");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_byte && wb_adr_i == ADDR_FLAGS && wbyte[BIT_LOW] && !changed[BIT_LOW] |=>
        !st_reg.flags[BIT_LOW];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_high_irq;
    @(posedge clk_sys) disable iff (sys_rst)
      st_reg.flags[BIT_HIGH] && st_reg.irq_en[BIT_HIGH] |-> module_irq;
  endproperty
  a_high_irq: assert property (p_high_irq) else $error("high request missing");

  property p_low_irq;
    @(posedge clk_sys) disable iff (sys_rst)
      st_reg.flags[BIT_LOW] && st_reg.irq_en[BIT_LOW] |-> module_irq;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low request missing");

  property p_off_flag;
    @(posedge clk_sys) disable iff (sys_rst)
      !sense_on && st_reg.cond_prev[BIT_HIGH] && !frozen |=> st_reg.flags[BIT_HIGH];
  endproperty
  a_off_flag: assert property (p_off_flag) else $error("disable raised no flag");

  property p_stop_flags;
    @(posedge clk_sys) disable iff (sys_rst)
      stop_mode && !(wr_byte && wb_adr_i == ADDR_FLAGS) |=> $stable(st_reg.flags);
  endproperty
  a_stop_flags: assert property (p_stop_flags) else $error("flags moved in stop");

  property p_pause_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      frozen |=> $stable(st_reg.cond_prev);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("condition moved while paused");

  property p_rdata_upper;
    @(posedge clk_sys) disable iff (sys_rst)
      wb_ack_o |-> wb_dat_o[DAT_W-1:8] == 24'h000000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
endmodule

// file: comparator_model.sv
// Analog comparator stand-in: reports a level only while a sense path is closed
module comparator_model (
  input wire logic path_on,
  input wire logic lvl_high,
  input wire logic lvl_low,
  output logic cmp_high,
  output logic cmp_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Output delay is off the clock grid, so the design has to synchronise it
  assign #13 cmp_high = path_on & lvl_high;
  assign #13 cmp_low = path_on & lvl_low;
endmodule

// file: supply_voltage_sense_ctrl_bench.sv
module supply_voltage_sense_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sense_pkg::*;
  logic clk_sys, sys_rst, cyc, stb, we, stop_mode, lvl_high, lvl_low;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, q;
  wire logic [DAT_W-1:0] rdat;
  wire logic ack, cmp_high, cmp_low, hsel, sa, ua, sc, uc, irq;
  wire logic [1:0] lsel;
  int error_cnt = 0;
  int n_compared = 0;
  int tick = 0;

  supply_voltage_sense_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_high(cmp_high), .cmp_low(cmp_low),
    .stop_mode(stop_mode), .high_level_select(hsel), .low_level_select(lsel),
    .battery_sense_pin_adc_path(sa), .chip_supply_pin_adc_path(ua),
    .battery_sense_pin_cmp_path(sc), .chip_supply_pin_cmp_path(uc), .module_irq(irq));

  comparator_model cmp (.path_on(sc | uc), .lvl_high(lvl_high), .lvl_low(lvl_low),
    .cmp_high(cmp_high), .cmp_low(cmp_low));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    tick++;
    if (tick == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; request held until ack is sampled, then released
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [ADR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h000000, e}, q);
  endtask

  task automatic outs(input logic [6:0] e);
    chk("outputs", {25'h0, e}, {25'h0, hsel, lsel, ua, uc, sa, sc});
  endtask

  task automatic t_regs();
    rd("select", ADDR_SELECT, 8'h00);
    rd("flags", ADDR_FLAGS, 8'h00);
    wr(ADDR_SELECT, 8'hFF);
    rd("select", ADDR_SELECT, 8'h73);
    outs(7'h73);
    wr(ADDR_SELECT, 8'h2C);
    rd("select", ADDR_SELECT, 8'h20);
    wr(ADDR_SELECT, 8'h4C);
    rd("select", ADDR_SELECT, 8'h4C);
    outs(7'h4C);
    wr(ADDR_SELECT, 8'h1F);
    outs(7'h13);
    wr(ADDR_IRQ_EN, 8'hFF);
    rd("irq_enable", ADDR_IRQ_EN, 8'h03);
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rd("status", ADDR_STATUS, 8'h00);
    wr(4'h2, 8'hFF);
    rd("unmapped", 4'h2, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_cond();
    // Path enable changes only while both interrupt enables are clear
    wr(ADDR_SELECT, 8'h01);
    lvl_high <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd("status", ADDR_STATUS, 8'h02);
    rd("flags", ADDR_FLAGS, 8'h02);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_EN, 8'h02);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_FLAGS, 8'h01);
    rd("flags", ADDR_FLAGS, 8'h02);
    wr(ADDR_IRQ_EN, 8'h01);
    lvl_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd("status", ADDR_STATUS, 8'h03);
    rd("flags", ADDR_FLAGS, 8'h03);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_FLAGS, 8'h03);
    rd("flags", ADDR_FLAGS, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_SELECT, 8'h00);
    repeat (6) @(posedge clk_sys);
    rd("status", ADDR_STATUS, 8'h00);
    rd("flags", ADDR_FLAGS, 8'h03);
    lvl_high <= 1'b0;
    lvl_low <= 1'b0;
    wr(ADDR_FLAGS, 8'h03);
    $display("test cond done");
  endtask

  task automatic t_stop();
    // Interrupt enables are clear here, so the path change is harmless
    wr(ADDR_SELECT, 8'h4F);
    lvl_high <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(ADDR_FLAGS, 8'h03);
    // A live high condition must not raise a flag on entering or leaving stop
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    outs(7'h40);
    rd("select", ADDR_SELECT, 8'h43);
    rd("flags", ADDR_FLAGS, 8'h00);
    stop_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    outs(7'h43);
    rd("flags", ADDR_FLAGS, 8'h00);
    rd("status", ADDR_STATUS, 8'h02);
    lvl_high <= 1'b0;
    $display("test stop done");
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {cyc, stb, we, stop_mode, lvl_high, lvl_low} = 6'h00;
    adr = 4'h0;
    wdat = 32'h00000000;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_cond();
    t_stop();
    end_sim();
  end
endmodule
